// >>> nkp_ports.sv
// Key return, key source, bit I/O and external interrupt ports
`timescale 1ns/100ps
`default_nettype none
module nkp_ports
    import nkp_pkg::*;
#(
    parameter int NW = 4
)(
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    // Data memory side (port registers)
    input  wire logic [7:0]    mem_addr,
    input  wire logic          mem_wr,
    input  wire logic [NW-1:0] mem_wdata,
    output logic      [NW-1:0] mem_rdata,
    // Register file side
    input  wire logic [7:0]    rf_addr,
    input  wire logic          regfile_write_op,
    input  wire logic [NW-1:0] rf_wdata,
    output logic      [NW-1:0] rf_rdata,
    input  wire logic          irq_flag_clr,
    // Standby control
    input  wire logic          standby,
    output logic               standby_wake,
    // Pins
    input  wire logic [NW-1:0] key_return_a_pin,
    input  wire logic [NW-1:0] key_return_b_pin,
    output logic      [NW-1:0] key_source_c_oe,
    output logic      [NW-1:0] key_source_d_oe,
    input  wire logic [NW-1:0] bitio_pin_in,
    output logic      [NW-1:0] bitio_pin_out,
    output logic      [NW-1:0] bitio_pin_oe,
    output logic      [NW-1:0] bitio_pullup_en,
    input  wire logic          ext_int_pin,
    output logic               ext_irq_flag
);
    if (NW != 4)
    begin : g_nw_check
        $error("nkp_ports: NW must be 4");
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [NW-1:0] ret_a_s;
    logic [NW-1:0] ret_b_s;
    logic [NW-1:0] bitio_s;
    logic [0:0]    int_s;

    nkp_sync #(.WIDTH(NW)) u_sync_a (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (key_return_a_pin),
        .q       (ret_a_s)
    );
    nkp_sync #(.WIDTH(NW)) u_sync_b (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (key_return_b_pin),
        .q       (ret_b_s)
    );
    nkp_sync #(.WIDTH(NW)) u_sync_e (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (bitio_pin_in),
        .q       (bitio_s)
    );
    nkp_sync #(.WIDTH(1)) u_sync_int (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (ext_int_pin),
        .q       (int_s)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [NW-1:0] key_source_c_latch_ff;
    logic [NW-1:0] key_source_d_latch_ff;
    logic [NW-1:0] bitio_port_data_ff;
    logic [NW-1:0] bitio_direction_select_ff;
    logic [NW-1:0] bitio_pullup_select_ff;
    logic          int_prev_ff;
    logic          irq_flag_ff;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // Ports A and B have no write path at all
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            key_source_c_latch_ff <= NKP_RST_NIBBLE;
            key_source_d_latch_ff <= NKP_RST_NIBBLE;
            bitio_port_data_ff    <= NKP_RST_NIBBLE;
        end
        else if (mem_wr)
        begin
            if (hit(mem_addr, NKP_ADDR_SRCC))
                key_source_c_latch_ff <= mem_wdata; // R4
            if (hit(mem_addr, NKP_ADDR_SRCD))
                key_source_d_latch_ff <= mem_wdata; // R5
            if (hit(mem_addr, NKP_ADDR_PORTE))
                bitio_port_data_ff <= mem_wdata; // R15
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bitio_direction_select_ff <= NKP_ALL_INPUT; // R10
            bitio_pullup_select_ff    <= NKP_RST_NIBBLE;
        end
        else if (regfile_write_op)
        begin
            if (hit(rf_addr, NKP_ADDR_DIR))
                bitio_direction_select_ff <= rf_wdata; // R7
            if (hit(rf_addr, NKP_ADDR_PULLUP))
                bitio_pullup_select_ff <= rf_wdata; // R9
        end
    end

    // Sync flops reset high, so an idle-low pin would fake an edge;
    // detection waits until the real pin value has reached int_prev_ff
    logic [1:0] arm_cnt_ff;
    logic       edge_armed;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            arm_cnt_ff <= 2'h0;
        else if (arm_cnt_ff != NKP_ARM_CYCLES)
            arm_cnt_ff <= 2'(arm_cnt_ff + 2'h1);
    end

    assign edge_armed = (arm_cnt_ff == NKP_ARM_CYCLES);

    // Edge flag: a new edge wins over a clear in the same cycle
    logic int_edge;
    assign int_edge = edge_armed & (int_s[0] ^ int_prev_ff); // R16

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            int_prev_ff <= 1'b1;
            irq_flag_ff <= 1'b0;
        end
        else
        begin
            int_prev_ff <= int_s[0];
            if (int_edge)
                irq_flag_ff <= 1'b1; // R11
            else if (irq_flag_clr)
                irq_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read paths
    // ----------------------------------------
    logic [NW-1:0] porte_view;
    assign porte_view = (bitio_direction_select_ff & bitio_port_data_ff)
                      | (~bitio_direction_select_ff & bitio_s); // R8

    always_comb
    begin
        mem_rdata = '0;
        case (mem_addr)
            NKP_ADDR_RETA:  mem_rdata = ret_a_s; // R1
            NKP_ADDR_RETB:  mem_rdata = ret_b_s; // R2
            NKP_ADDR_SRCC:  mem_rdata = key_source_c_latch_ff; // R4
            NKP_ADDR_SRCD:  mem_rdata = key_source_d_latch_ff; // R5
            NKP_ADDR_PORTE: mem_rdata = porte_view; // R8
            default:        mem_rdata = '0;
        endcase
    end

    always_comb
    begin
        rf_rdata = '0;
        case (rf_addr)
            NKP_ADDR_DIR:    rf_rdata = bitio_direction_select_ff;
            NKP_ADDR_PULLUP: rf_rdata = bitio_pullup_select_ff;
            NKP_ADDR_IRQF:   rf_rdata[NKP_FLAG_BIT] = irq_flag_ff;
            NKP_ADDR_LEVEL:  rf_rdata[NKP_FLAG_BIT] = int_s[0]; // R12
            default:         rf_rdata = '0;
        endcase
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Open drain: enable pulls low; standby forces every pin low
    function automatic logic [NW-1:0] od_enable(input logic          sleep,
                                                input logic [NW-1:0] latch);
        od_enable = sleep ? '1 : ~latch;
    endfunction

    assign key_source_c_oe = od_enable(standby, key_source_c_latch_ff); // R6
    assign key_source_d_oe = od_enable(standby, key_source_d_latch_ff); // R6
    // Direction acts combinationally so the latch appears the same cycle
    assign bitio_pin_oe    = bitio_direction_select_ff; // R7 R13
    assign bitio_pin_out   = bitio_port_data_ff; // R13
    // Pull-up not gated by direction; software removes it itself
    assign bitio_pullup_en = bitio_pullup_select_ff; // R9 R14
    // Synchronised pins: wake lags a key press by two clocks
    // Limitation: sys_clk must keep running during standby
    assign standby_wake    = standby & ~(&{ret_a_s, ret_b_s}); // R3
    assign ext_irq_flag    = irq_flag_ff;

    // ----------------------------------------
    // Checks: register writes
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    port_c_write_a: assert property (mem_wr && mem_addr == NKP_ADDR_SRCC // R4
        |=> key_source_c_latch_ff == $past(mem_wdata))
        else $error("port C latch");

    port_d_write_a: assert property (mem_wr && mem_addr == NKP_ADDR_SRCD // R5
        |=> key_source_d_latch_ff == $past(mem_wdata))
        else $error("port D latch");

    port_e_write_a: assert property (mem_wr && mem_addr == NKP_ADDR_PORTE // R15
        |=> bitio_pin_out == $past(mem_wdata))
        else $error("port E latch");

    dir_out_a: assert property (regfile_write_op && rf_addr == NKP_ADDR_DIR // R7 R13
        |=> bitio_pin_oe == $past(rf_wdata))
        else $error("direction");

    pullup_a: assert property (regfile_write_op && rf_addr == NKP_ADDR_PULLUP // R9
        |=> bitio_pullup_en == $past(rf_wdata))
        else $error("pull-up");

    ro_write_a: assert property (mem_wr // R16
        && (mem_addr == NKP_ADDR_RETA || mem_addr == NKP_ADDR_RETB)
        |=> $stable(key_source_c_latch_ff) && $stable(key_source_d_latch_ff)
            && $stable(bitio_port_data_ff)) else $error("write to input port");

    c_latch_hold_a: assert property (!(mem_wr && mem_addr == NKP_ADDR_SRCC) // R4
        |=> $stable(key_source_c_latch_ff))
        else $error("port C latch moved");

    d_latch_hold_a: assert property (!(mem_wr && mem_addr == NKP_ADDR_SRCD) // R5
        |=> $stable(key_source_d_latch_ff))
        else $error("port D latch moved");

    dir_hold_a: assert property (!(regfile_write_op && rf_addr == NKP_ADDR_DIR) // R7
        |=> $stable(bitio_pin_oe))
        else $error("direction moved");

    // ----------------------------------------
    // Checks: read paths
    // ----------------------------------------
    reta_read_a: assert property (mem_addr == NKP_ADDR_RETA // R1
        |-> mem_rdata == ret_a_s)
        else $error("port A read");

    retb_read_a: assert property (mem_addr == NKP_ADDR_RETB // R2
        |-> mem_rdata == ret_b_s)
        else $error("port B read");

    srcc_read_a: assert property (mem_addr == NKP_ADDR_SRCC // R4
        |-> mem_rdata == key_source_c_latch_ff)
        else $error("port C read");

    srcd_read_a: assert property (mem_addr == NKP_ADDR_SRCD // R5
        |-> mem_rdata == key_source_d_latch_ff)
        else $error("port D read");

    porte_read_a: assert property (mem_addr == NKP_ADDR_PORTE // R8
        |-> mem_rdata == porte_view && (mem_rdata & bitio_pin_oe)
            == (bitio_port_data_ff & bitio_pin_oe)) else $error("port E read");

    dir_read_a: assert property (rf_addr == NKP_ADDR_DIR // R7
        |-> rf_rdata == bitio_pin_oe)
        else $error("direction read");

    level_read_a: assert property (rf_addr == NKP_ADDR_LEVEL // R12
        |-> rf_rdata == {3'h0, int_s[0]})
        else $error("level flag");

    irq_read_a: assert property (rf_addr == NKP_ADDR_IRQF // R11
        |-> rf_rdata == {3'h0, ext_irq_flag})
        else $error("irq flag read");

    // ----------------------------------------
    // Checks: pins and standby
    // ----------------------------------------
    standby_low_a: assert property (standby // R6
        |-> key_source_c_oe == '1 && key_source_d_oe == '1)
        else $error("standby drive");

    awake_drive_a: assert property (!standby // R4 R5
        |-> key_source_c_oe == ~key_source_c_latch_ff && key_source_d_oe == ~key_source_d_latch_ff)
        else $error("source drive");

    wake_a: assert property (standby && (ret_a_s & ret_b_s) != '1 // R3
        |-> standby_wake)
        else $error("wake missed");

    wake_idle_a: assert property (!standby || (ret_a_s & ret_b_s) == '1 // R3
        |-> !standby_wake)
        else $error("false wake");

    switch_drive_a: assert property (regfile_write_op && rf_addr == NKP_ADDR_DIR && !mem_wr // R13
        |=> (bitio_pin_out & bitio_pin_oe) == ($past(bitio_port_data_ff) & $past(rf_wdata)))
        else $error("switch drive");

    pullup_hold_a: assert property (!(regfile_write_op && rf_addr == NKP_ADDR_PULLUP) // R9
        |=> $stable(bitio_pullup_en))
        else $error("pull-up moved");

    // ----------------------------------------
    // Checks: interrupt
    // ----------------------------------------
    edge_flag_a: assert property (edge_armed && int_s[0] != $past(int_s[0]) // R11
        |=> irq_flag_ff)
        else $error("edge lost");

    edge_wins_a: assert property (int_edge && irq_flag_clr // R11
        |=> irq_flag_ff)
        else $error("clear beat edge");

    flag_clear_a: assert property (irq_flag_clr && !int_edge // R11
        |=> !irq_flag_ff)
        else $error("clear lost");

    flag_hold_a: assert property (irq_flag_ff && !irq_flag_clr // R11
        |=> irq_flag_ff)
        else $error("flag dropped");

    flag_quiet_a: assert property (!irq_flag_ff && int_s[0] == $past(int_s[0]) // R16
        |=> !irq_flag_ff)
        else $error("flag without edge");

    no_false_edge_a: assert property (!edge_armed // R16
        |=> !irq_flag_ff)
        else $error("edge after reset");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    irq_set_c:   cover property (int_edge ##1 irq_flag_ff);
    irq_clear_c: cover property (irq_flag_ff ##1 !irq_flag_ff);
    wake_c:      cover property (standby && standby_wake);
    dir_flip_c:  cover property (bitio_pin_oe == '0 ##1 bitio_pin_oe != '0);
    ro_write_c:  cover property (mem_wr && mem_addr == NKP_ADDR_RETA);
endmodule
`default_nettype wire

// >>> nkp_pkg.sv
// Constants for the nibble port block
// How it works
// [R1] Reading address 70h returns live key return port A pins; input only.
// [R2] Reading address 71h returns live key return port B pins; input only.
// [R3] In standby, any low key return pin releases standby at once; here standby_wake follows two clocks later, after the synchronisers.
// [R4] Port C at 72h: write loads open-drain latch, read returns latch.
// [R5] Port D at 73h: write loads open-drain latch, read returns latch.
// [R6] In standby, ports C and D drive all pins low regardless of latch.
// [R7] Each port E pin direction comes from its bit at register 27h.
// [R8] Port E read at 6Fh: latch for output bits, pin for input bits.
// [R9] Port E pull-ups per bit from 17h; kept even in output mode.
// [R10] After reset all port E pins are inputs.
// [R11] Any edge on the interrupt pin sets flag bit 0 at 3Eh.
// [R12] Level flag bit 0 at 0Fh mirrors the interrupt pin level.
// [R13] Switching a port E bit to output drives its latch at once.
// [R14] Software clears the pull-up bit to remove pull-up in output mode.
// [R15] Port E data writes update the latch for every bit.
// [R16] Interrupt pin synchronised before edge detection; input-only writes ignored.
`default_nettype none
package nkp_pkg;
    localparam logic [7:0] NKP_ADDR_PULLUP = 8'h17;
    localparam logic [7:0] NKP_ADDR_DIR    = 8'h27;
    localparam logic [7:0] NKP_ADDR_IRQF   = 8'h3e;
    localparam logic [7:0] NKP_ADDR_LEVEL  = 8'h0f;
    localparam logic [7:0] NKP_ADDR_PORTE  = 8'h6f;
    localparam logic [7:0] NKP_ADDR_RETA   = 8'h70;
    localparam logic [7:0] NKP_ADDR_RETB   = 8'h71;
    localparam logic [7:0] NKP_ADDR_SRCC   = 8'h72;
    localparam logic [7:0] NKP_ADDR_SRCD   = 8'h73;
    localparam logic [3:0] NKP_RST_NIBBLE  = 4'h0;
    localparam logic [3:0] NKP_ALL_INPUT   = 4'h0;
    localparam int         NKP_FLAG_BIT    = 0;
    // Clocks after reset before the edge detector trusts the pin
    localparam logic [1:0] NKP_ARM_CYCLES  = 2'h3;
endpackage
`default_nettype wire

// >>> nkp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module nkp_sync
    import nkp_pkg::*;
#(
    parameter int WIDTH = 4
)(
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    if (WIDTH < 1)
    begin : g_width_check
        $error("nkp_sync: WIDTH must be positive");
    end

    // Reset to high: idle pins sit pulled up
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_ff <= '1;
            q_ff    <= '1;
        end
        else
        begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// >>> nkp_matrix_model.sv
// Key matrix and pin environment around the nibble ports
`timescale 1ns/100ps
`default_nettype none
module nkp_matrix_model (
    input  wire logic       sys_clk,
    input  wire logic [3:0] key_a,
    input  wire logic [3:0] key_b,
    input  wire logic [3:0] src_c_oe,
    input  wire logic [3:0] src_d_oe,
    input  wire logic [3:0] e_out,
    input  wire logic [3:0] e_oe,
    input  wire logic [3:0] e_pu,
    input  wire logic [3:0] ext_en,
    input  wire logic [3:0] ext_val,
    output logic      [3:0] ret_a,
    output logic      [3:0] ret_b,
    output logic      [3:0] e_pin
);
    logic [3:0] flt = 4'h5;

    // Undriven lines wander so a stale value never reads as valid
    always_ff @(posedge sys_clk)
        flt <= ~flt;

    // Pressed key shorts a return line to any low source line
    assign ret_a = ~(key_a & {4{|src_c_oe}});
    assign ret_b = ~(key_b & {4{|src_d_oe}});

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (e_oe[i])
                e_pin[i] = e_out[i];
            else if (ext_en[i])
                e_pin[i] = ext_val[i];
            else
                e_pin[i] = e_pu[i] ? 1'b1 : flt[i];
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the nibble port block
`timescale 1ns/100ps
`default_nettype none
module tb
    import nkp_pkg::*;
;
    logic       sys_clk, nrst, mem_wr, regfile_write_op, irq_flag_clr, standby;
    logic       standby_wake, ext_int_pin, ext_irq_flag;
    logic [7:0] mem_addr, rf_addr;
    logic [3:0] mem_wdata, mem_rdata, rf_wdata, rf_rdata, key_return_a_pin, key_return_b_pin;
    logic [3:0] key_source_c_oe, key_source_d_oe, bitio_pin_in, bitio_pin_out;
    logic [3:0] bitio_pin_oe, bitio_pullup_en, key_a, key_b, ext_en, ext_val;
    int         fails, num_checks;

    nkp_ports dut (.sys_clk, .nrst, .mem_addr, .mem_wr, .mem_wdata, .mem_rdata, .rf_addr,
        .regfile_write_op, .rf_wdata, .rf_rdata, .irq_flag_clr, .standby, .standby_wake,
        .key_return_a_pin, .key_return_b_pin, .key_source_c_oe, .key_source_d_oe,
        .bitio_pin_in, .bitio_pin_out, .bitio_pin_oe, .bitio_pullup_en, .ext_int_pin,
        .ext_irq_flag);

    nkp_matrix_model env (.sys_clk, .key_a, .key_b, .src_c_oe(key_source_c_oe),
        .src_d_oe(key_source_d_oe), .e_out(bitio_pin_out), .e_oe(bitio_pin_oe),
        .e_pu(bitio_pullup_en), .ext_en, .ext_val, .ret_a(key_return_a_pin),
        .ret_b(key_return_b_pin), .e_pin(bitio_pin_in));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [3:0] s, input logic [3:0] e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input bit rf, input logic [7:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        mem_addr <= a;
        rf_addr <= a;
        mem_wdata <= d;
        rf_wdata <= d;
        mem_wr <= !rf;
        regfile_write_op <= rf;
        @(posedge sys_clk);
        mem_wr <= 1'b0;
        regfile_write_op <= 1'b0;
    endtask

    // Read data is combinational, so it is sampled mid-cycle
    task automatic rd(input bit rf, input logic [7:0] a, input logic [3:0] e, input string nm);
        @(posedge sys_clk);
        mem_addr <= a;
        rf_addr <= a;
        @(negedge sys_clk);
        chk(nm, rf ? rf_rdata : mem_rdata, e);
    endtask

    task automatic wait_flag(input logic v);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (ext_irq_flag !== v && n < 8)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("irq flag", {3'h0, ext_irq_flag}, {3'h0, v});
        if (ext_irq_flag !== v)
            wrap_up();
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        {mem_addr, mem_wr, mem_wdata, rf_addr, regfile_write_op, rf_wdata} = '0;
        {irq_flag_clr, standby, ext_int_pin, key_a, key_b, ext_en, ext_val} = '0;
        nrst = 1'b0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(0, NKP_ADDR_SRCC, 4'h0, "c latch");
        rd(0, NKP_ADDR_SRCD, 4'h0, "d latch");
        rd(1, NKP_ADDR_DIR, 4'h0, "e dir");
        chk("e oe", bitio_pin_oe, 4'h0);
        chk("c oe", key_source_c_oe, 4'hf);
        $display("test reset done");
        rd(0, NKP_ADDR_RETA, 4'hf, "ret a");
        wr(0, NKP_ADDR_RETA, 4'h0);
        key_a <= 4'h4;
        key_b <= 4'h2;
        repeat (3) @(posedge sys_clk);
        rd(0, NKP_ADDR_RETA, 4'hb, "ret a");
        wr(0, NKP_ADDR_RETB, 4'hf);
        rd(0, NKP_ADDR_RETB, 4'hd, "ret b");
        $display("test return done");
        wr(0, NKP_ADDR_SRCC, 4'h5);
        rd(0, NKP_ADDR_SRCC, 4'h5, "c latch");
        chk("c oe", key_source_c_oe, 4'ha);
        wr(0, NKP_ADDR_SRCD, 4'h9);
        rd(0, NKP_ADDR_SRCD, 4'h9, "d latch");
        chk("d oe", key_source_d_oe, 4'h6);
        $display("test source done");
        key_a <= 4'h0;
        key_b <= 4'h0;
        wr(0, NKP_ADDR_SRCC, 4'hf);
        wr(0, NKP_ADDR_SRCD, 4'hf);
        standby <= 1'b1;
        @(negedge sys_clk);
        chk("c oe", key_source_c_oe, 4'hf);
        chk("d oe", key_source_d_oe, 4'hf);
        chk("wake", {3'h0, standby_wake}, 4'h0);
        @(posedge sys_clk);
        key_b <= 4'h8;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("wake", {3'h0, standby_wake}, 4'h1);
        @(posedge sys_clk);
        key_b <= 4'h0;
        standby <= 1'b0;
        @(negedge sys_clk);
        chk("c oe", key_source_c_oe, 4'h0);
        $display("test standby done");
        ext_en <= 4'hf;
        ext_val <= 4'h5;
        wr(0, NKP_ADDR_PORTE, 4'ha);
        @(negedge sys_clk);
        chk("e out", bitio_pin_out, 4'ha);
        rd(0, NKP_ADDR_PORTE, 4'h5, "e data");
        ext_en <= 4'hc;
        wr(1, NKP_ADDR_DIR, 4'h3);
        @(negedge sys_clk);
        chk("e oe", bitio_pin_oe, 4'h3);
        chk("e pin", bitio_pin_in, 4'h6);
        repeat (2) @(posedge sys_clk);
        rd(0, NKP_ADDR_PORTE, 4'h6, "e data");
        wr(1, NKP_ADDR_PULLUP, 4'hf);
        rd(1, NKP_ADDR_PULLUP, 4'hf, "pullup");
        wr(1, NKP_ADDR_PULLUP, 4'he);
        rd(1, NKP_ADDR_PULLUP, 4'he, "pullup");
        chk("pu en", bitio_pullup_en, 4'he);
        $display("test bit io done");
        rd(1, NKP_ADDR_LEVEL, 4'h0, "level");
        rd(1, NKP_ADDR_IRQF, 4'h0, "irq reg");
        @(posedge sys_clk);
        ext_int_pin <= 1'b1;
        wait_flag(1'b1);
        rd(1, NKP_ADDR_IRQF, 4'h1, "irq reg");
        rd(1, NKP_ADDR_LEVEL, 4'h1, "level");
        @(posedge sys_clk);
        irq_flag_clr <= 1'b1;
        @(posedge sys_clk);
        irq_flag_clr <= 1'b0;
        wait_flag(1'b0);
        @(posedge sys_clk);
        ext_int_pin <= 1'b0;
        wait_flag(1'b1);
        rd(1, NKP_ADDR_LEVEL, 4'h0, "level");
        $display("test interrupt done");
        wrap_up();
    end
endmodule
`default_nettype wire
